// *** bench/rfdec_targets.sv ***
/*
 * Far-side model of the three decoder targets: register RAM, program RAM
 * and the control page, each giving read data for its registered address.
 * Assumes the decoder holds each target's address for the data cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module rfdec_targets
    import rfdec_pkg::*;
(
    input  wire rfdec_sel_s  i_ram,
    input  wire rfdec_sel_s  i_pram,
    input  wire rfdec_sel_s  i_ctrl,
    output var  rfdec_data_t o_ram_rdata,
    output var  rfdec_data_t o_pram_rdata,
    output var  rfdec_data_t o_ctrl_rdata,
    output var  logic        o_ctrl_hole
);
    // Data follows the low address byte, XORed with 5a for register RAM, a5 for program RAM, unchanged for the control page
    assign o_ram_rdata  = i_ram.addr[7:0] ^ 8'h5a;
    assign o_pram_rdata = i_pram.addr[7:0] ^ 8'ha5;
    assign o_ctrl_rdata = i_ctrl.addr[7:0];
    // Offset fe of the control page is reserved
    assign o_ctrl_hole  = (i_ctrl.addr[7:0] == 8'hfe);
endmodule : rfdec_targets

`default_nettype wire

// *** bench/tb_rfdec_decoder.sv ***
/*
 * Self-checking bench for the register file address decoder.
 * Assumes the target model in rfdec_targets.sv and a 2KB RAM variant.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_rfdec_decoder;
    import rfdec_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_pram_map = 1'b0;
    rfdec_req_s  i_req = '0;
    logic        hole;
    rfdec_data_t ram_rd, pram_rd, ctrl_rd, o_rdata;
    rfdec_sel_s  o_ram, o_pram, o_ctrl;
    logic        o_rvalid, o_pram_in_rf;
    int          errors = 0;
    int          samples_checked = 0;

    always #25 i_mclk = ~i_mclk;

    rfdec_decoder #(.RAM_KB(2)) rfdec_decoder_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_req(i_req), .i_pram_map(i_pram_map), .i_ctrl_hole(hole),
        .i_ram_rdata(ram_rd), .i_pram_rdata(pram_rd), .i_ctrl_rdata(ctrl_rd),
        .o_ram(o_ram), .o_pram(o_pram), .o_ctrl(o_ctrl), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_pram_in_rf(o_pram_in_rf));
    rfdec_targets rfdec_targets_inst (.i_ram(o_ram), .i_pram(o_pram), .i_ctrl(o_ctrl),
        .o_ram_rdata(ram_rd), .o_pram_rdata(pram_rd), .o_ctrl_rdata(ctrl_rd),
        .o_ctrl_hole(hole));

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    task automatic do_reset(input logic map);
        i_pram_map = map;
        i_rst = 1'b1;
        repeat (10) @(posedge i_mclk);
        #1;
        chk(o_rvalid === 1'b0 && o_rdata === 8'h00, "reset read side");
        chk(o_ram === '0 && o_pram === '0 && o_ctrl === '0, "reset strobes");
        chk(o_pram_in_rf === 1'b0, "reset remap");
        i_rst = 1'b0;
        @(posedge i_mclk) #1;
    endtask : do_reset

    // One access: strobe checked just after the edge that takes it, read data one edge later
    task automatic acc(input logic rd, input logic wr, input rfdec_addr_t a,
                       input rfdec_data_t wd, input rfdec_tgt_e t,
                       input rfdec_addr_t ta, input rfdec_data_t d);
        rfdec_sel_s e;
        rfdec_sel_s z;
        e = '{rd, wr, ta, wd};
        z = '0;
        @(posedge i_mclk) #1 i_req = '{rd, wr, a, wd};
        @(posedge i_mclk) #1 i_req = '0;
        chk(o_ram === ((t == RFDEC_TGT_RAM) ? e : z), "ram strobe");
        chk(o_pram === ((t == RFDEC_TGT_PRAM) ? e : z), "pram strobe");
        chk(o_ctrl === ((t == RFDEC_TGT_CTRL) ? e : z), "ctrl strobe");
        @(posedge i_mclk) #1;
        chk(o_rvalid === rd, "rvalid");
        if (rd) begin
            chk(o_rdata === d, "rdata");
        end
    endtask : acc

    task automatic t_ram;
        acc(1, 0, 12'h000, 8'h00, RFDEC_TGT_RAM, 12'h000, 8'h5a);
        acc(0, 1, 12'h7ff, 8'h3c, RFDEC_TGT_RAM, 12'h7ff, 8'h00);
        acc(1, 0, 12'h7ff, 8'h00, RFDEC_TGT_RAM, 12'h7ff, 8'ha5);
        acc(1, 1, 12'h020, 8'h55, RFDEC_TGT_RAM, 12'h020, 8'h7a);
        acc(1, 0, 12'h800, 8'h00, RFDEC_TGT_NONE, 12'h000, 8'h00);
        acc(0, 1, 12'hbff, 8'h11, RFDEC_TGT_NONE, 12'h000, 8'h00);
        chk(o_pram_in_rf === 1'b0, "remap off");
        $display("test ram done");
    endtask : t_ram

    task automatic t_ctrl;
        acc(1, 0, 12'hf00, 8'h00, RFDEC_TGT_CTRL, 12'hf00, 8'h00);
        acc(1, 0, 12'hfff, 8'h00, RFDEC_TGT_CTRL, 12'hfff, 8'hff);
        acc(0, 1, 12'hfff, 8'h77, RFDEC_TGT_CTRL, 12'hfff, 8'h00);
        acc(1, 0, 12'heff, 8'h00, RFDEC_TGT_NONE, 12'h000, 8'h00);
        acc(1, 0, 12'hffe, 8'h00, RFDEC_TGT_CTRL, 12'hffe, 8'h00);
        $display("test ctrl done");
    endtask : t_ctrl

    task automatic t_remap;
        chk(o_pram_in_rf === 1'b1, "remap on");
        i_pram_map = 1'b0;
        acc(1, 0, 12'h800, 8'h00, RFDEC_TGT_PRAM, 12'h000, 8'ha5);
        acc(0, 1, 12'hbff, 8'h42, RFDEC_TGT_PRAM, 12'h3ff, 8'h00);
        acc(1, 0, 12'hc00, 8'h00, RFDEC_TGT_NONE, 12'h000, 8'h00);
        acc(1, 0, 12'h7ff, 8'h00, RFDEC_TGT_RAM, 12'h7ff, 8'ha5);
        chk(o_pram_in_rf === 1'b1, "strap held");
        $display("test remap done");
    endtask : t_remap

    // Reads on consecutive cycles: register RAM, then remapped program RAM
    task automatic t_b2b;
        rfdec_sel_s e1;
        rfdec_sel_s e2;
        e1 = '{1'b1, 1'b0, 12'h010, 8'h00};
        e2 = '{1'b1, 1'b0, 12'h100, 8'h00};
        @(posedge i_mclk) #1 i_req = '{1'b1, 1'b0, 12'h010, 8'h00};
        @(posedge i_mclk) #1 i_req = '{1'b1, 1'b0, 12'h900, 8'h00};
        chk(o_ram === e1 && o_pram === '0, "b2b ram strobe");
        @(posedge i_mclk) #1 i_req = '0;
        chk(o_pram === e2 && o_ram === '0, "b2b pram strobe");
        chk(o_rvalid === 1'b1 && o_rdata === 8'h4a, "b2b ram data");
        @(posedge i_mclk) #1;
        chk(o_rvalid === 1'b1 && o_rdata === 8'ha5, "b2b pram data");
        @(posedge i_mclk) #1;
        chk(o_rvalid === 1'b0, "b2b valid pulse");
        $display("test b2b done");
    endtask : t_b2b

    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        do_reset(1'b0);
        t_ram;
        t_ctrl;
        do_reset(1'b1);
        t_remap;
        t_b2b;
        give_verdict;
    end
endmodule : tb_rfdec_decoder

`default_nettype wire

// *** logic/rfdec_cfg.svh ***
/*
 * Constants for the register file address decoder: address map bounds,
 * widths and fill values.
 * Assumes it is included by bare name from logic/ sources only.
 */
`ifndef RFDEC_CFG_SVH
`define RFDEC_CFG_SVH

`define RFDEC_ADDR_W      12
`define RFDEC_DATA_W      8
`define RFDEC_CTRL_BASE   12'hf00
`define RFDEC_CTRL_LAST   12'hfff
`define RFDEC_RAM_BASE    12'h000
`define RFDEC_RAM_1K      12'h400
`define RFDEC_RAM_2K      12'h800
`define RFDEC_PRAM_SIZE   12'h400
`define RFDEC_FILL_BYTE   8'h00

`endif

// *** logic/rfdec_decoder.sv ***
/*
 * Register file address decoder: steers each core access to register RAM,
 * remapped program RAM, the control page or nowhere, and returns read data
 * two cycles after the request.
 * Assumes targets return read data combinationally for the address given.
 */
// Summary of operation
// - Accept a 12-bit address covering a 4096-byte register file.
// - Addresses F00H to FFFH go to the control register page, never RAM.
// - Reserved control page reads return undefined data.
// - Register RAM starts at 000H, 1KB or 2KB per variant.
// - Unimplemented addresses below control page: read undefined, writes ignored.
// - Program RAM may map at 800H-BFFH (2KB parts) or 400H-7FFH (1KB parts).
// - Operand reads and result writes all pass through the decoder.
`timescale 1ns/10ps
`default_nettype none
`include "rfdec_cfg.svh"

module rfdec_decoder
    import rfdec_pkg::*;
#(
    parameter int RAM_KB = 2
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire rfdec_req_s  i_req,
    input  wire logic        i_pram_map,
    input  wire logic        i_ctrl_hole,
    input  wire rfdec_data_t i_ram_rdata,
    input  wire rfdec_data_t i_pram_rdata,
    input  wire rfdec_data_t i_ctrl_rdata,
    output var  rfdec_sel_s  o_ram,
    output var  rfdec_sel_s  o_pram,
    output var  rfdec_sel_s  o_ctrl,
    output var  rfdec_data_t o_rdata,
    output var  logic        o_rvalid,
    output var  logic        o_pram_in_rf
);

    // Only the two documented RAM sizes have a map
    if (RAM_KB != 1 && RAM_KB != 2) begin : g_ram_kb_check
        $error("RAM_KB must be 1 or 2");
    end

    localparam rfdec_addr_t RAM_TOP = (RAM_KB == 2) ? `RFDEC_RAM_2K : `RFDEC_RAM_1K;

    // Classify an address under the given remap state
    function automatic rfdec_tgt_e classify(input rfdec_addr_t a, input logic remap);
        rfdec_tgt_e t;
        t = RFDEC_TGT_NONE;
        if (a >= `RFDEC_CTRL_BASE) begin
            t = RFDEC_TGT_CTRL;
        end else if (a < RAM_TOP) begin
            t = RFDEC_TGT_RAM;
        end else if (remap && a < RAM_TOP + `RFDEC_PRAM_SIZE) begin
            t = RFDEC_TGT_PRAM;
        end
        return t;
    endfunction : classify

    // Remap strap, caught on the first edge after reset release
    logic        remap_reg, remap_next;
    logic        strap_done_reg, strap_done_next;

    always_comb begin
        remap_next      = remap_reg;
        strap_done_next = 1'b1;
        if (!strap_done_reg) begin
            remap_next = i_pram_map;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            remap_reg      <= 1'b0;
            strap_done_reg <= 1'b0;
        end else begin
            remap_reg      <= remap_next;
            strap_done_reg <= strap_done_next;
        end
    end

    // Access pipeline: strobes and read data registered
    rfdec_sel_s  ram_reg, ram_next, pram_reg, pram_next, ctrl_reg, ctrl_next;
    rfdec_tgt_e  tgt_reg, tgt_next;
    logic        rd_reg, rd_next;
    rfdec_data_t rdata_reg, rdata_next;
    logic        rvalid_reg, rvalid_next;
    rfdec_tgt_e  tgt_now;

    always_comb begin
        rfdec_sel_s base;
        base       = '{rd: i_req.rd, wr: i_req.wr, addr: i_req.addr, wdata: i_req.wdata};
        tgt_now    = classify(i_req.addr, remap_reg);
        ram_next   = '0;
        pram_next  = '0;
        ctrl_next  = '0;
        // Unmapped addresses get no strobe so writes change nothing
        case (tgt_now)
            RFDEC_TGT_RAM: begin
                ram_next = base;
            end
            RFDEC_TGT_PRAM: begin
                pram_next      = base;
                pram_next.addr = i_req.addr - RAM_TOP;
            end
            RFDEC_TGT_CTRL: begin
                ctrl_next = base;
            end
            default: begin
                ram_next = '0;
            end
        endcase
        tgt_next    = tgt_now;
        rd_next     = i_req.rd;
        rvalid_next = rd_reg;
        rdata_next  = `RFDEC_FILL_BYTE;
        if (rd_reg) begin
            case (tgt_reg)
                RFDEC_TGT_RAM: begin
                    rdata_next = i_ram_rdata;
                end
                RFDEC_TGT_PRAM: begin
                    rdata_next = i_pram_rdata;
                end
                RFDEC_TGT_CTRL: begin
                    // Hole flag and data both belong to the address now on o_ctrl
                    rdata_next = i_ctrl_hole ? `RFDEC_FILL_BYTE : i_ctrl_rdata;
                end
                default: begin
                    rdata_next = `RFDEC_FILL_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ram_reg    <= '0;
            pram_reg   <= '0;
            ctrl_reg   <= '0;
            tgt_reg    <= RFDEC_TGT_NONE;
            rd_reg     <= 1'b0;
            rdata_reg  <= `RFDEC_FILL_BYTE;
            rvalid_reg <= 1'b0;
        end else begin
            ram_reg    <= ram_next;
            pram_reg   <= pram_next;
            ctrl_reg   <= ctrl_next;
            tgt_reg    <= tgt_next;
            rd_reg     <= rd_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign o_ram        = ram_reg;
    assign o_pram       = pram_reg;
    assign o_ctrl       = ctrl_reg;
    assign o_rdata      = rdata_reg;
    assign o_rvalid     = rvalid_reg;
    assign o_pram_in_rf = remap_reg;

    sequence read_issued_s;
        i_req.rd;
    endsequence

    sequence answer_given_s;
        ##2 o_rvalid;
    endsequence

    ctrl_page_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_req.wr && i_req.addr >= `RFDEC_CTRL_BASE) |=> (o_ctrl.wr && !o_ram.wr && !o_pram.wr))
        else $error("control page write not routed to control page");

    ram_low_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_req.wr && i_req.addr < RAM_TOP) |=> (o_ram.wr && o_ram.addr == $past(i_req.addr)))
        else $error("register RAM write not routed");

    hole_write_drop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_req.wr && tgt_now == RFDEC_TGT_NONE) |=> !(o_ram.wr || o_pram.wr || o_ctrl.wr))
        else $error("unmapped write reached a target");

    pram_map_on_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (remap_reg && i_req.wr && i_req.addr >= RAM_TOP
            && i_req.addr < RAM_TOP + `RFDEC_PRAM_SIZE)
        |=> (o_pram.wr && o_pram.addr == $past(i_req.addr) - RAM_TOP))
        else $error("program RAM remap write not routed");

    pram_map_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !remap_reg |=> !o_pram.wr && !o_pram.rd)
        else $error("program RAM strobed while not remapped");

    read_answer_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        read_issued_s |-> answer_given_s)
        else $error("read answered late or not at all");

    strap_static_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        strap_done_reg |=> $stable(o_pram_in_rf))
        else $error("remap state changed after reset release");

    fill_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_req.rd && tgt_now == RFDEC_TGT_NONE) |-> ##2 (o_rdata == `RFDEC_FILL_BYTE))
        else $error("undefined read not driven as zero");

    ctrl_hole_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (o_ctrl.rd && i_ctrl_hole) |=> (o_rdata == `RFDEC_FILL_BYTE))
        else $error("reserved control read not zero");

    ram_read_data_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_ram.rd |=> (o_rdata == $past(i_ram_rdata)))
        else $error("register RAM read data not returned");

    pram_read_data_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_pram.rd |=> (o_rdata == $past(i_pram_rdata)))
        else $error("program RAM read data not returned");

    ctrl_read_data_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (o_ctrl.rd && !i_ctrl_hole) |=> (o_rdata == $past(i_ctrl_rdata)))
        else $error("control page read data not returned");

    rvalid_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_req.rd |-> ##2 !o_rvalid)
        else $error("read valid raised without a read");

endmodule : rfdec_decoder

`default_nettype wire

// *** logic/rfdec_pkg.sv ***
/*
 * Types shared by the register file address decoder.
 * Assumes rfdec_cfg.svh is on the include path.
 */
`default_nettype none
`include "rfdec_cfg.svh"

package rfdec_pkg;

    typedef logic [`RFDEC_ADDR_W-1:0] rfdec_addr_t;
    typedef logic [`RFDEC_DATA_W-1:0] rfdec_data_t;

    // Target of one decoded access
    typedef enum logic [1:0] {
        RFDEC_TGT_RAM  = 2'h0,
        RFDEC_TGT_PRAM = 2'h1,
        RFDEC_TGT_CTRL = 2'h2,
        RFDEC_TGT_NONE = 2'h3
    } rfdec_tgt_e;

    // Access request from the core
    typedef struct packed {
        logic        rd;
        logic        wr;
        rfdec_addr_t addr;
        rfdec_data_t wdata;
    } rfdec_req_s;

    // Strobes to one target
    typedef struct packed {
        logic        rd;
        logic        wr;
        rfdec_addr_t addr;
        rfdec_data_t wdata;
    } rfdec_sel_s;

endpackage : rfdec_pkg

`default_nettype wire
